// ### common/pcrp_defines.svh
`ifndef PCRP_DEFINES_SVH
`define PCRP_DEFINES_SVH

// register byte offsets on the apb side
`define PCRP_CTRL_OFS        12'h000
`define PCRP_INT_STATUS_OFS  12'h004
`define PCRP_INT_CLEAR_OFS   12'h008
`define PCRP_INT_MASK_OFS    12'h00C
`define PCRP_FILL_OFS        12'h010
`define PCRP_DRAIN_OFS       12'h014
`define PCRP_BASE_OFS        12'h018
`define PCRP_CTX_OFS         12'h01C
// counter windows, one word per counter, two words per free counter
`define PCRP_AGG_LOW_PAGE    4'h1
`define PCRP_AGG_HIGH_PAGE   4'h2
`define PCRP_MISC_PAGE       4'h3
`define PCRP_FREE_BASE       8'h00
`define PCRP_BOOL_BASE       8'h40
`define PCRP_CUST_BASE       8'h60

// control register fields
`define PCRP_CTRL_COUNT_BIT  0
`define PCRP_CTRL_FMT_LSB    1
`define PCRP_CTRL_TIMER_BIT  4
`define PCRP_CTRL_RESET      32'h0000_0000

// interrupt layout shared by status, clear and mask
`define PCRP_INT_HALF_BIT    28
`define PCRP_MASK_RESET      1'b1

// format select codes
`define PCRP_FMT_A_SHORT     3'h0
`define PCRP_FMT_A_BC        3'h2
`define PCRP_FMT_FULL        3'h5
`define PCRP_FMT_CB          3'h7

// report lengths in words
`define PCRP_LEN_SHORT       7'h10
`define PCRP_LEN_A_BC        7'h20
`define PCRP_LEN_FULL        7'h40

// report identifier fields
`define PCRP_ID_CTX_VALID    25
`define PCRP_ID_REASON_TIMER 19
`define PCRP_ID_START_BIT    18
`define PCRP_ID_TIMER_EN     16

// elapsed time advances once per this many ns
`define PCRP_TS_NS           80
`define PCRP_CLK_NS          20
`define PCRP_TS_CYCLES       (`PCRP_TS_NS / `PCRP_CLK_NS)

`endif

// ### common/pcrp_pkg.sv
`default_nettype none
package pcrp_pkg;
  // sequencer states of the report packer
  typedef enum logic [1:0] {
    PCRP_IDLE,
    PCRP_LOAD,
    PCRP_EMIT
  } pcrp_state_t;

  // one word headed for the report ring buffer
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
  } pcrp_wr_t;

  // software control of the packer
  typedef struct packed {
    logic       timer_en;
    logic [2:0] fmt;
    logic       count_en;
  } pcrp_ctl_t;
endpackage
`default_nettype wire

// ### core/pcrp_packer.sv
// Operation
// - all interrupt registers share one bit layout
// - timer reports crossing half fill set bit 28
// - bits 31:29 reserved, software writes zero
// - unit never sets interrupt bits 27:0
// - format 000: header, A7-A10, A11-A18
// - format 010: as 000 plus B row, C row
// - format 111: header, C0-C3, then B0-B7
// - format 101: header, A0-A35, high bytes, B, C
// - counters survive power context save and restore
// - upper word per A0-A31, A32-A35 single word
// - A4, A6, A19, A20 add free-running words
// - layout follows format field at report time
// - counters snapshot atomically, low and high split
// - report id bit 18 shows start trigger fired
//
// Our own choices: the address map and the APB interface to the registers.
`include "pcrp_defines.svh"
`default_nettype none
module pcrp_packer
  import pcrp_pkg::*;
#(
  parameter int RING_WORDS = 1024, // report buffer capacity in words
  parameter int NUM_AGG    = 36,
  parameter int NUM_BC     = 8
) (
  input  wire logic               i_clock,
  input  wire logic               i_reset,
  // apb slave
  input  wire logic               i_psel,
  input  wire logic               i_penable,
  input  wire logic               i_pwrite,
  input  wire logic [11:0]        i_paddr,
  input  wire logic [31:0]        i_pwdata,
  output logic      [31:0]        o_prdata,
  output logic                    o_pready,
  output logic                    o_pslverr,
  // counting events, one count per cycle per bit
  input  wire logic [NUM_AGG-1:0] i_agg_event,
  input  wire logic [NUM_BC-1:0]  i_bool_event,
  input  wire logic [NUM_BC-1:0]  i_cust_event,
  input  wire logic               i_start_trigger,
  // report requests and power context
  input  wire logic               i_cmd_report,
  input  wire logic               i_timer_report,
  input  wire logic               i_ctx_valid,
  input  wire logic               i_ctx_save,
  input  wire logic               i_ctx_restore,
  // memory write port toward the report ring buffer
  output pcrp_wr_t                o_wr,
  output logic                    o_wr_valid,
  input  wire logic               i_wr_ready,
  output logic                    o_busy,
  output logic                    o_irq
);
  localparam int FREE_N = 4;
  localparam int PW     = $clog2(RING_WORDS);
  localparam logic [PW:0] HALF = (PW+1)'(RING_WORDS / 2);
  localparam logic [PW:0] FULL = (PW+1)'(RING_WORDS);
  localparam logic [2:0]  TS_LAST = 3'(`PCRP_TS_CYCLES - 1);

  // report length per format, zero for codes with no layout
  function automatic logic [6:0] rpt_len(input logic [2:0] f);
    unique case (f)
      `PCRP_FMT_A_SHORT: rpt_len = `PCRP_LEN_SHORT;
      `PCRP_FMT_A_BC:    rpt_len = `PCRP_LEN_A_BC;
      `PCRP_FMT_FULL:    rpt_len = `PCRP_LEN_FULL;
      `PCRP_FMT_CB:      rpt_len = `PCRP_LEN_SHORT;
      default:           rpt_len = 7'h00;
    endcase
  endfunction

  // free counter k shadows aggregate 4, 6, 19, 20
  function automatic int free_src(input int k);
    unique case (k)
      0:       free_src = 4;
      1:       free_src = 6;
      2:       free_src = 19;
      default: free_src = 20;
    endcase
  endfunction

  // live counters and their power context copies
  logic [39:0] agg_reg  [NUM_AGG];
  logic [39:0] agg_next [NUM_AGG];
  logic [39:0] free_reg [FREE_N];
  logic [39:0] free_next[FREE_N];
  logic [31:0] bc_reg   [2*NUM_BC];  // booleans then customs
  logic [31:0] bc_next  [2*NUM_BC];
  logic [39:0] agg_save [NUM_AGG];
  logic [39:0] free_save[FREE_N];
  logic [31:0] bc_save  [2*NUM_BC];
  pcrp_ctl_t   ctl_reg, ctl_next;        // software control fields
  logic        start_reg, start_next;     // start trigger has fired
  logic [31:0] tick_reg, tick_next;       // engine tick count
  logic [31:0] time_reg, time_next;       // elapsed time word
  logic [2:0]  tdiv_reg, tdiv_next;       // elapsed time divider

  // counting: restore wins over normal increments; a save does not stop them
  always_comb begin
    logic [2*NUM_BC-1:0] bc_ev;
    bc_ev      = {i_cust_event, i_bool_event};
    start_next = start_reg;
    tick_next  = tick_reg + 32'h0000_0001;
    tdiv_next  = (tdiv_reg == TS_LAST) ? 3'h0 : tdiv_reg + 3'h1;
    time_next  = (tdiv_reg == TS_LAST) ? time_reg + 32'h0000_0001
                                       : time_reg;
    if (!ctl_reg.count_en) begin
      start_next = 1'b0;                 // disable ends counting
    end else if (i_start_trigger) begin
      start_next = 1'b1;
    end
    for (int n = 0; n < NUM_AGG; n++) begin
      agg_next[n] = agg_reg[n];
      if (i_ctx_restore) begin
        agg_next[n] = agg_save[n];
      end else if (ctl_reg.count_en && i_agg_event[n]) begin
        agg_next[n] = agg_reg[n] + 40'h00_0000_0001;
      end
    end
    for (int k = 0; k < FREE_N; k++) begin
      free_next[k] = free_reg[k];
      if (i_ctx_restore) begin
        free_next[k] = free_save[k];
      end else if (i_agg_event[free_src(k)]) begin
        // free words ignore the enable
        free_next[k] = free_reg[k] + 40'h00_0000_0001;
      end
    end
    for (int b = 0; b < 2*NUM_BC; b++) begin
      bc_next[b] = bc_reg[b];
      if (i_ctx_restore) begin
        bc_next[b] = bc_save[b];
      end else if (start_reg && bc_ev[b]) begin
        // b and c counters wait for the start trigger
        bc_next[b] = bc_reg[b] + 32'h0000_0001;
      end
    end
  end

  // counter registers; the save copy is loaded on a save pulse
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      start_reg <= 1'b0;
      tick_reg  <= 32'h0000_0000;
      time_reg  <= 32'h0000_0000;
      tdiv_reg  <= 3'h0;
      for (int n = 0; n < NUM_AGG; n++) begin
        agg_reg[n]  <= 40'h00_0000_0000;
        agg_save[n] <= 40'h00_0000_0000;
      end
      for (int k = 0; k < FREE_N; k++) begin
        free_reg[k]  <= 40'h00_0000_0000;
        free_save[k] <= 40'h00_0000_0000;
      end
      for (int b = 0; b < 2*NUM_BC; b++) begin
        bc_reg[b]  <= 32'h0000_0000;
        bc_save[b] <= 32'h0000_0000;
      end
    end else begin
      start_reg <= start_next;
      tick_reg  <= tick_next;
      time_reg  <= time_next;
      tdiv_reg  <= tdiv_next;
      agg_reg   <= agg_next;
      free_reg  <= free_next;
      bc_reg    <= bc_next;
      if (i_ctx_save) begin
        agg_save  <= agg_reg;
        free_save <= free_reg;
        bc_save   <= bc_reg;
      end
    end
  end

  // software state
  logic        stat_reg, stat_next;      // half full, sticky
  logic        mask_reg, mask_next;      // 1 masks the event
  logic [31:0] base_reg, base_next;      // ring buffer base address
  logic [31:0] ctxid_reg, ctxid_next;    // context identifier word
  logic [PW:0] fill_reg, fill_next;      // words not yet drained
  logic [31:0] rd_data;
  logic        rd_ok;
  logic        acc, wr_acc;

  // report sequencer state
  pcrp_state_t st_reg, st_next;
  logic [5:0]  idx_reg, idx_next;        // word index in the report
  logic [6:0]  len_reg, len_next;
  logic [2:0]  fmt_reg, fmt_next;
  logic        tmr_reg, tmr_next;        // report came from the timer
  logic [31:0] hdr_reg [4];
  logic [31:0] hdr_next[4];
  logic [39:0] snap_agg [NUM_AGG];
  logic [31:0] snap_bc  [2*NUM_BC];
  logic [PW-1:0] wptr_reg, wptr_next;
  logic [31:0] word;
  logic        take, wr_done;

  assign acc     = i_psel && i_penable && o_pready;
  assign wr_acc  = acc && i_pwrite;
  assign wr_done = o_wr_valid && i_wr_ready;

  // apb read decode of the register map
  always_comb begin
    logic [5:0] r;
    r       = i_paddr[7:2];
    rd_data = 32'h0000_0000;
    rd_ok   = 1'b1;
    unique case (i_paddr[11:8])
      4'h0: begin
        unique case (i_paddr)
          `PCRP_CTRL_OFS:       rd_data = 32'(ctl_reg);
          // same bit position in status and mask
          `PCRP_INT_STATUS_OFS: rd_data = {3'h0, stat_reg, 28'h000_0000};
          `PCRP_INT_MASK_OFS:   rd_data = {3'h0, mask_reg, 28'h000_0000};
          `PCRP_FILL_OFS:       rd_data = 32'(fill_reg);
          `PCRP_BASE_OFS:       rd_data = base_reg;
          `PCRP_CTX_OFS:        rd_data = ctxid_reg;
          `PCRP_INT_CLEAR_OFS,
          `PCRP_DRAIN_OFS:      rd_data = 32'h0000_0000; // write only
          default:              rd_ok   = 1'b0;
        endcase
      end
      `PCRP_AGG_LOW_PAGE: begin
        if (32'(r) < NUM_AGG) rd_data = agg_reg[r][31:0];
        else                  rd_ok   = 1'b0;
      end
      `PCRP_AGG_HIGH_PAGE: begin
        // upper words exist for counters 0 to 31 only
        if (r < 6'd32) rd_data = {24'h00_0000, agg_reg[r][39:32]};
        else           rd_ok   = 1'b0;
      end
      `PCRP_MISC_PAGE: begin
        if (i_paddr[7:0] < 8'(`PCRP_FREE_BASE + 8'h20)) begin
          // even word low, odd word high of free counter
          rd_data = r[0] ? {24'h00_0000, free_reg[r[2:1]][39:32]}
                         : free_reg[r[2:1]][31:0];
        end else if (i_paddr[7:0] >= `PCRP_BOOL_BASE &&
                     i_paddr[7:0] < 8'(`PCRP_CUST_BASE + 8'h20)) begin
          rd_data = bc_reg[r[3:0]];
        end else begin
          rd_ok = 1'b0;
        end
      end
      default: rd_ok = 1'b0;
    endcase
  end

  // apb writes, interrupt status and ring fill level
  always_comb begin
    ctl_next   = ctl_reg;
    mask_next  = mask_reg;
    base_next  = base_reg;
    ctxid_next = ctxid_reg;
    stat_next  = stat_reg;
    fill_next  = fill_reg;
    if (wr_acc) begin
      unique case (i_paddr)
        `PCRP_CTRL_OFS:      ctl_next   = pcrp_ctl_t'(i_pwdata[4:0]);
        // only bit 28 is kept; 31:29 and 27:0 stay zero
        `PCRP_INT_MASK_OFS:  mask_next  = i_pwdata[`PCRP_INT_HALF_BIT];
        `PCRP_INT_CLEAR_OFS: begin
          if (i_pwdata[`PCRP_INT_HALF_BIT]) stat_next = 1'b0;
        end
        `PCRP_DRAIN_OFS: begin
          fill_next = (32'(fill_reg) > i_pwdata) ?
                      fill_reg - (PW+1)'(i_pwdata) : '0;
        end
        `PCRP_BASE_OFS:      base_next  = {i_pwdata[31:2], 2'b00};
        `PCRP_CTX_OFS:       ctxid_next = i_pwdata;
        default:             ;
      endcase
    end
    if (wr_done && fill_next != FULL) begin
      fill_next = fill_next + (PW+1)'(1);
    end
    // timer report crossing half full; set beats clear
    if (wr_done && tmr_reg && fill_reg < HALF && fill_next >= HALF) begin
      stat_next = 1'b1;
    end
  end

  // software state and apb answer registers
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      ctl_reg   <= pcrp_ctl_t'(`PCRP_CTRL_RESET);
      mask_reg  <= `PCRP_MASK_RESET;
      stat_reg  <= 1'b0;
      base_reg  <= 32'h0000_0000;
      ctxid_reg <= 32'h0000_0000;
      fill_reg  <= '0;
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
      o_irq     <= 1'b0;
    end else begin
      ctl_reg   <= ctl_next;
      mask_reg  <= mask_next;
      stat_reg  <= stat_next;
      base_reg  <= base_next;
      ctxid_reg <= ctxid_next;
      fill_reg  <= fill_next;
      // one wait state keeps the read mux off the ready path
      o_pready  <= i_psel && i_penable && !o_pready;
      o_prdata  <= (i_psel && i_penable && !o_pready && !i_pwrite) ?
                   rd_data : 32'h0000_0000;
      o_pslverr <= i_psel && i_penable && !o_pready && !rd_ok;
      o_irq     <= stat_next && !mask_next;
    end
  end

  // report trigger; a command wins over a timer in the same cycle
  assign take = (st_reg == PCRP_IDLE) && (i_cmd_report || i_timer_report)
                && rpt_len(ctl_reg.fmt) != 7'h00;

  // word selection from the snapshot, row by row upward
  always_comb begin
    int i;
    int k;
    i    = int'(idx_reg);
    k    = 0;
    word = 32'h0000_0000;                // gaps read as zero
    if (i < 4) begin
      word = hdr_reg[i[1:0]];
    end else begin
      unique case (fmt_reg)
        `PCRP_FMT_A_SHORT: begin
          if (i < 16) word = snap_agg[i + 3][31:0];
        end
        `PCRP_FMT_A_BC: begin
          if (i < 16)      word = snap_agg[i + 3][31:0];
          else if (i < 32) word = snap_bc[i - 16];
        end
        `PCRP_FMT_CB: begin
          if (i < 8)       word = snap_bc[i + 4];
          else if (i < 16) word = snap_bc[i - 8];
        end
        `PCRP_FMT_FULL: begin
          if (i < 40) begin
            word = snap_agg[i - 4][31:0];
          end else if (i < 48) begin
            k    = 4 * (i - 40);
            // four high bytes, lowest counter in the low lane
            word = {snap_agg[k + 3][39:32], snap_agg[k + 2][39:32],
                    snap_agg[k + 1][39:32], snap_agg[k][39:32]};
          end else begin
            word = snap_bc[i - 48];
          end
        end
        default: ;
      endcase
    end
  end

  // sequencer next state
  always_comb begin
    st_next   = st_reg;
    idx_next  = idx_reg;
    len_next  = len_reg;
    fmt_next  = fmt_reg;
    tmr_next  = tmr_reg;
    wptr_next = wptr_reg;
    hdr_next  = hdr_reg;
    unique case (st_reg)
      PCRP_IDLE: begin
        if (take) begin
          st_next  = PCRP_LOAD;
          idx_next = 6'h00;
          fmt_next = ctl_reg.fmt;
          len_next = rpt_len(ctl_reg.fmt);
          tmr_next = !i_cmd_report;
          hdr_next[0] = 32'h0000_0000;
          hdr_next[0][`PCRP_ID_CTX_VALID]    = i_ctx_valid;
          hdr_next[0][`PCRP_ID_REASON_TIMER] = !i_cmd_report;
          hdr_next[0][`PCRP_ID_START_BIT]    = start_reg;
          hdr_next[0][`PCRP_ID_TIMER_EN]     = ctl_reg.timer_en;
          hdr_next[1] = time_reg;
          hdr_next[2] = ctxid_reg;
          hdr_next[3] = tick_reg;
        end
      end
      PCRP_LOAD: st_next = PCRP_EMIT;
      PCRP_EMIT: begin
        if (wr_done) begin
          wptr_next = wptr_reg + PW'(1);
          idx_next  = idx_reg + 6'h01;
          st_next   = (7'(idx_reg) == len_reg - 7'h01) ? PCRP_IDLE
                                                       : PCRP_LOAD;
        end
      end
    endcase
  end

  // sequencer registers; snapshot of aggregate, boolean and custom counters in one edge
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      st_reg     <= PCRP_IDLE;
      idx_reg    <= 6'h00;
      len_reg    <= 7'h00;
      fmt_reg    <= 3'h0;
      tmr_reg    <= 1'b0;
      wptr_reg   <= '0;
      o_wr_valid <= 1'b0;
      o_wr       <= '0;
      o_busy     <= 1'b0;
      for (int h = 0; h < 4; h++) hdr_reg[h] <= 32'h0000_0000;
    end else begin
      st_reg   <= st_next;
      idx_reg  <= idx_next;
      len_reg  <= len_next;
      fmt_reg  <= fmt_next;
      tmr_reg  <= tmr_next;
      wptr_reg <= wptr_next;
      hdr_reg  <= hdr_next;
      o_busy   <= st_next != PCRP_IDLE;
      if (take) begin
        snap_agg <= agg_reg;
        snap_bc  <= bc_reg;
      end
      if (st_reg == PCRP_LOAD) begin
        o_wr_valid <= 1'b1;
        o_wr.data  <= word;
        o_wr.addr  <= base_reg + {wptr_reg, 2'b00};
      end else if (wr_done) begin
        o_wr_valid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ### dv/pcrp_asserts.sv
`include "pcrp_defines.svh"
`default_nettype none
module pcrp_asserts
  import pcrp_pkg::*;
(
  input wire logic        i_clock,
  input wire logic        i_reset,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire pcrp_wr_t    o_wr,
  input wire logic        o_wr_valid,
  input wire logic        i_wr_ready,
  input wire logic        o_busy,
  input wire logic        o_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);
  // word handed over to the ring in this cycle
  wire logic wr_acc = o_wr_valid && i_wr_ready;
  // completed apb write, seen at the answering edge
  wire logic apb_wr = i_psel && i_penable && o_pready && i_pwrite;
  // read answer from an interrupt register
  wire logic rd_int = o_pready && !i_pwrite &&
    (i_paddr == `PCRP_INT_STATUS_OFS || i_paddr == `PCRP_INT_MASK_OFS);

  chk_ready_pulse: assert property (o_pready |=> !o_pready)
    else $error("pready longer than one cycle");
  chk_ready_late: assert property (i_psel && i_penable &&
    $past(i_psel && !i_penable) |-> !o_pready ##1 o_pready)
    else $error("pready not in second access cycle");
  chk_err_ready: assert property (o_pslverr |-> o_pready)
    else $error("pslverr without pready");
  chk_data_idle: assert property (!o_pready |-> o_prdata == 32'h0000_0000)
    else $error("read data outside answer");
  chk_int_layout: assert property (rd_int |->
    o_prdata[31:29] == 3'h0 && o_prdata[27:0] == 28'h000_0000)
    else $error("interrupt bit outside bit 28");
  chk_wr_hold: assert property (o_wr_valid && !i_wr_ready |=>
    o_wr_valid && $stable(o_wr)) else $error("ring word dropped");
  chk_wr_gap: assert property (wr_acc |=> !o_wr_valid)
    else $error("no idle cycle after word");
  chk_addr_up: assert property (wr_acc ##2 o_wr_valid |->
    o_wr.addr == $past(o_wr.addr, 2) + 32'h0000_0004 ||
    o_wr.addr < $past(o_wr.addr, 2)) else $error("address not ascending");
  chk_valid_busy: assert property (o_wr_valid |-> o_busy)
    else $error("word outside report");
  chk_irq_clear: assert property (apb_wr && !o_busy &&
    i_paddr == `PCRP_INT_CLEAR_OFS && i_pwdata[28] |-> ##[1:3] !o_irq)
    else $error("irq not cleared");
  chk_irq_mask: assert property (apb_wr &&
    i_paddr == `PCRP_INT_MASK_OFS && i_pwdata[28] |-> ##[1:3] !o_irq)
    else $error("irq not masked");

  cover property (wr_acc);
  cover property ($rose(o_irq));
  cover property (o_pslverr);
endmodule
`default_nettype wire

// ### dv/pcrp_ring_model.sv
`default_nettype none
// memory side of the report ring; logs words in acceptance order
module pcrp_ring_model
  import pcrp_pkg::*;
(
  input wire logic     i_clock,
  input wire logic     i_reset,
  input wire pcrp_wr_t i_wr,
  input wire logic     i_wr_valid,
  input wire logic     i_stall,
  output logic         o_wr_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] q[$];       // accepted words, oldest first
  logic        tgl = 1'b0; // slow mode accepts every other cycle
  // capture on handshake; ascending order is kept by the queue
  always @(posedge i_clock) begin
    if (i_wr_valid && o_wr_ready) q.push_back(i_wr.data);
    tgl <= ~tgl;
    o_wr_ready <= !i_reset && (!i_stall || tgl);
  end
endmodule
`default_nettype wire

// ### dv/pcrp_packer_tb.sv
`include "pcrp_defines.svh"
`default_nettype none
module pcrp_packer_tb
  import pcrp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clock = 0, i_reset = 1, psel = 0, pen = 0, pwr = 0;
  logic        stall = 0, st = 0, cmd = 0, tmr = 0, sv = 0, rs = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic        pready, pslverr, wv, wrdy, busy, irq;
  logic [35:0] agg = '0;
  logic [7:0]  bev = '0, cev = '0;
  pcrp_wr_t    wr;
  int          n_mismatch = 0, checked = 0, cyc = 0;
  logic [2:0]  fm [4] = '{`PCRP_FMT_A_SHORT, `PCRP_FMT_A_BC, `PCRP_FMT_CB,
                         `PCRP_FMT_FULL};
  int          ln [4] = '{16, 32, 16, 64};

  // small ring keeps the half-full crossing short
  pcrp_packer #(.RING_WORDS(16)) i_pcrp_packer (.i_clock(i_clock),
    .i_reset(i_reset), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_agg_event(agg),
    .i_bool_event(bev), .i_cust_event(cev), .i_start_trigger(st),
    .i_cmd_report(cmd), .i_timer_report(tmr), .i_ctx_valid(1'b1),
    .i_ctx_save(sv), .i_ctx_restore(rs), .o_wr(wr), .o_wr_valid(wv),
    .i_wr_ready(wrdy), .o_busy(busy), .o_irq(irq));
  pcrp_ring_model i_pcrp_ring_model (.i_clock(i_clock), .i_reset(i_reset),
    .i_wr(wr), .i_wr_valid(wv), .i_stall(stall), .o_wr_ready(wrdy));

  initial forever #10 i_clock = ~i_clock;
  // hang guard, far above the few hundred cycles needed
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("mismatches %0d of %0d checks", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge i_clock);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clock);
    pen <= 1'b1;
    // only the bench timeout ends this wait
    do begin
      @(posedge i_clock);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x,
    input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(r, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask

  // counter n was fed n events, boolean n events, custom n+1
  function automatic logic [31:0] exp_w(input logic [2:0] f, input int i);
    int v;
    case (f)
      3'h7: v = (i < 8) ? i - 3 : i - 8;
      3'h5: v = (i < 40) ? i - 4 : (i < 48) ? 0 : (i < 56) ? i - 48 : i - 55;
      default: v = (i < 16) ? i + 3 : (i < 24) ? i - 16 : i - 23;
    endcase
    return 32'(v);
  endfunction

  // select a layout, request one report, compare id bits, context word and every counter word
  task automatic run_rpt(input logic [2:0] f, input int len, input logic t);
    int n;
    i_pcrp_ring_model.q.delete();
    wr_reg(`PCRP_CTRL_OFS, {27'h0, t, f, 1'b1});
    @(posedge i_clock);
    if (t) tmr <= 1'b1;
    else cmd <= 1'b1;
    @(posedge i_clock);
    tmr <= 1'b0;
    cmd <= 1'b0;
    n = 0;
    while (i_pcrp_ring_model.q.size() < len && n < 2000) begin
      @(posedge i_clock);
      n++;
    end
    repeat (6) @(posedge i_clock);
    chk(32'(i_pcrp_ring_model.q.size()), 32'(len));
    chk({31'h0, i_pcrp_ring_model.q[0][18]}, 32'h0000_0001);
    chk({31'h0, i_pcrp_ring_model.q[0][19]}, {31'h0, t});
    chk(i_pcrp_ring_model.q[2], 32'hC0DE_0001);
    for (int i = 4; i < len; i++) begin
      chk(i_pcrp_ring_model.q[i], exp_w(f, i));
    end
  endtask

  initial begin
    repeat (4) @(posedge i_clock);
    i_reset <= 1'b0;
    rd(`PCRP_INT_MASK_OFS, 32'h1000_0000, 1'b0);
    rd(`PCRP_CTRL_OFS, 32'h0000_0000, 1'b0);
    rd(12'h020, 32'h0000_0000, 1'b1);
    wr_reg(`PCRP_BASE_OFS, 32'h0000_0000);
    wr_reg(`PCRP_CTX_OFS, 32'hC0DE_0001);
    wr_reg(`PCRP_CTRL_OFS, 32'h0000_0001);
    @(posedge i_clock) st <= 1'b1;
    @(posedge i_clock) st <= 1'b0;
    // staircase of events gives each aggregate and boolean counter its own index as count, each custom one more
    for (int k = 0; k < 36; k++) begin
      @(posedge i_clock);
      for (int n = 0; n < 36; n++) agg[n] <= (n > k);
      for (int n = 0; n < 8; n++) begin
        bev[n] <= (n > k);
        cev[n] <= (n >= k);
      end
    end
    @(posedge i_clock) {agg, bev, cev} <= '0;
    rd(12'h18C, 32'h0000_0023, 1'b0);
    rd(12'h27C, 32'h0000_0000, 1'b0);
    rd(12'h280, 32'h0000_0000, 1'b1);
    rd(12'h300, 32'h0000_0004, 1'b0);
    rd(12'h310, 32'h0000_0013, 1'b0);
    rd(12'h318, 32'h0000_0014, 1'b0);
    // counts made between save and restore must vanish
    @(posedge i_clock) sv <= 1'b1;
    @(posedge i_clock) {sv, agg, bev} <= {1'b0, 36'hF_FFFF_FFFF, 8'hFF};
    @(posedge i_clock) {rs, agg, bev} <= {1'b1, 36'h0, 8'h0};
    @(posedge i_clock) rs <= 1'b0;
    rd(12'h11C, 32'h0000_0007, 1'b0);
    rd(12'h34C, 32'h0000_0003, 1'b0);
    for (int j = 0; j < 4; j++) begin
      stall <= (j == 3);
      run_rpt(fm[j], ln[j], 1'b0);
    end
    stall <= 1'b0;
    chk({31'h0, irq}, 32'h0000_0000);
    wr_reg(`PCRP_DRAIN_OFS, 32'h0000_00FF);
    rd(`PCRP_FILL_OFS, 32'h0000_0000, 1'b0);
    wr_reg(`PCRP_INT_MASK_OFS, 32'h0000_0000);
    run_rpt(`PCRP_FMT_A_SHORT, 16, 1'b1);
    chk({31'h0, irq}, 32'h0000_0001);
    rd(`PCRP_INT_STATUS_OFS, 32'h1000_0000, 1'b0);
    wr_reg(`PCRP_INT_MASK_OFS, 32'h1000_0000);
    repeat (2) @(posedge i_clock);
    chk({31'h0, irq}, 32'h0000_0000);
    wr_reg(`PCRP_INT_MASK_OFS, 32'h0000_0000);
    wr_reg(`PCRP_INT_CLEAR_OFS, 32'h1000_0000);
    repeat (2) @(posedge i_clock);
    chk({31'h0, irq}, 32'h0000_0000);
    rd(`PCRP_INT_STATUS_OFS, 32'h0000_0000, 1'b0);
    report_and_stop();
  end
endmodule

bind pcrp_packer pcrp_asserts i_pcrp_asserts (.i_clock(i_clock),
  .i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_wr(o_wr), .o_wr_valid(o_wr_valid), .i_wr_ready(i_wr_ready),
  .o_busy(o_busy), .o_irq(o_irq));
`default_nettype wire
